// ---- scsml_ctrl.sv ----
// Serial control, status and modem-line registers behind the host I/O bus
`default_nettype none

module scsml_ctrl (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  // Host I/O bus
  input  wire scsml_pkg::scsml_req_t i_req,
  output logic [7:0]                 o_rdata,
  output logic                       o_rvalid,
  // Serial engine
  input  wire scsml_pkg::scsml_eng_t i_eng,
  output logic                       o_tx_wr,
  output logic [7:0]                 o_tx_data,
  output logic                       o_fmt_wr,
  output logic [7:0]                 o_fmt_data,
  output logic                       o_eng_idle,
  output logic                       o_tx_enable,
  output logic                       o_rx_enable,
  output logic                       o_send_break,
  output logic                       o_half_rate,
  // Connector pins
  input  wire logic                  i_cable_modem,
  input  wire logic                  i_hs_in,
  input  wire logic [2:0]            i_sense,
  output logic                       o_hs_a,
  output logic                       o_hs_b,
  output logic [3:0]                 o_line_out
);

  typedef enum logic [1:0] {
    ST_CTRL = 2'b01,
    ST_FMT  = 2'b10
  } scsml_state_t;

  scsml_state_t state_r;
  logic [7:0]   icw_r;
  logic [7:0]   scw_r;
  logic [7:0]   mlo_r;
  logic [7:0]   rx_data_r;
  logic         rx_full_r;
  logic [7:0]   rdata_r;
  logic         rvalid_r;
  logic         tx_wr_r;
  logic [7:0]   tx_data_r;
  logic         fmt_wr_r;
  logic [7:0]   fmt_data_r;
  logic         eng_idle_r;
  logic [2:0]   err_flags;
  logic [2:0]   err_set;
  logic         err_clr;
  logic [4:0]   pins_sync;
  logic         cable_modem;
  logic         hs_in;
  logic [2:0]   sense;
  logic [7:0]   wdata;
  logic         ctrl_access;
  logic         wr_icw;
  logic         wr_data;
  logic         wr_modem;
  logic         rd_data;
  logic         rd_modem;
  logic         soft_rst;
  logic         wr_ctrl;
  logic         wr_fmt;
  logic         wr_tx;
  logic         rd_rx;
  logic         rx_accept;
  logic [7:0]   status_word;
  logic [7:0]   modem_in_word;

  // Pins cross into the clock domain first
  scsml_sync #(
    .W (5)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async ({i_cable_modem, i_hs_in, i_sense}),
    .o_sync  (pins_sync)
  );

  assign cable_modem = pins_sync[4];
  assign hs_in       = pins_sync[3];
  assign sense       = pins_sync[2:0];

  // Request decode
  assign wdata       = i_req.wdata;
  assign ctrl_access = icw_r[scsml_pkg::ICW_CTRL_ACCESS];
  assign wr_icw      = i_req.wr && (i_req.sel == scsml_pkg::SEL_ICW);
  assign wr_data     = i_req.wr && (i_req.sel == scsml_pkg::SEL_DATA);
  assign wr_modem    = i_req.wr && (i_req.sel == scsml_pkg::SEL_MODEM);
  assign rd_data     = i_req.rd && (i_req.sel == scsml_pkg::SEL_DATA);
  assign rd_modem    = i_req.rd && (i_req.sel == scsml_pkg::SEL_MODEM);

  assign soft_rst = wr_icw && wdata[scsml_pkg::ICW_SOFT_RESET];

  // Control access steers the data path
  assign wr_ctrl = wr_data && ctrl_access && (state_r == ST_CTRL);
  assign wr_fmt  = wr_data && ctrl_access && (state_r == ST_FMT);
  // Transmit data only while transmitter enabled
  assign wr_tx   = wr_data && !ctrl_access && scw_r[scsml_pkg::SCW_TX_EN];
  // Data read empties the receive buffer
  assign rd_rx   = rd_data && !ctrl_access;

  assign rx_accept = i_eng.rx_new && scw_r[scsml_pkg::SCW_RX_EN];

  assign err_set[scsml_pkg::ERR_FRAMING] = (rx_accept && i_eng.frame_err) ||
                                           (scw_r[scsml_pkg::SCW_RX_EN] && i_eng.break_det);
  assign err_set[scsml_pkg::ERR_OVERRUN] = rx_accept && rx_full_r && !rd_rx;
  assign err_set[scsml_pkg::ERR_PARITY]  = rx_accept && i_eng.parity_err;
  assign err_clr = (wr_ctrl && wdata[scsml_pkg::SCW_ERR_CLR]) || soft_rst;

  scsml_err_flags #(
    .N (scsml_pkg::ERR_COUNT)
  ) u_err (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_set   (err_set),
    .i_clr   (err_clr),
    .o_flags (err_flags)
  );

  assign status_word = {hs_in,
                        1'b0,
                        err_flags[scsml_pkg::ERR_FRAMING],
                        err_flags[scsml_pkg::ERR_OVERRUN],
                        err_flags[scsml_pkg::ERR_PARITY],
                        i_eng.tx_empty,
                        rx_full_r,
                        i_eng.tx_ready && scw_r[scsml_pkg::SCW_TX_EN]};

  assign modem_in_word = cable_modem ? {5'h10, sense} : {6'h20, sense[1:0]};

  // Interface control word; reset bit never sticks
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      icw_r <= scsml_pkg::ICW_RESET;
    end else if (soft_rst) begin
      icw_r <= scsml_pkg::ICW_RESET;
    end else if (wr_icw) begin
      icw_r <= wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scw_r <= scsml_pkg::SCW_RESET;
    end else if (soft_rst) begin
      scw_r <= scsml_pkg::SCW_RESET;
    end else if (wr_ctrl) begin
      // Unused top bit kept as written; it drives nothing
      scw_r <= wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_CTRL;
    end else begin
      case (state_r)
        ST_CTRL: begin
          if (!soft_rst && wr_ctrl && wdata[scsml_pkg::SCW_ENG_RESET]) begin
            state_r <= ST_FMT;
          end
        end
        ST_FMT: begin
          if (soft_rst || wr_fmt) begin
            state_r <= ST_CTRL;
          end
        end
        default: begin
          state_r <= ST_CTRL;
        end
      endcase
    end
  end

  // Engine idle pulse and format word hand-off
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      eng_idle_r <= 1'b0;
      fmt_wr_r   <= 1'b0;
      fmt_data_r <= scsml_pkg::DAT_RESET;
    end else begin
      eng_idle_r <= soft_rst || (wr_ctrl && wdata[scsml_pkg::SCW_ENG_RESET]);
      fmt_wr_r   <= wr_fmt && !soft_rst;
      if (wr_fmt) begin
        fmt_data_r <= wdata;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_wr_r   <= 1'b0;
      tx_data_r <= scsml_pkg::DAT_RESET;
    end else begin
      tx_wr_r <= wr_tx;
      if (wr_tx) begin
        tx_data_r <= wdata;
      end
    end
  end

  // Receive holding register; arrival beats a same-cycle read
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_data_r <= scsml_pkg::DAT_RESET;
      rx_full_r <= 1'b0;
    end else if (soft_rst) begin
      rx_data_r <= scsml_pkg::DAT_RESET;
      rx_full_r <= 1'b0;
    end else if (rx_accept) begin
      rx_data_r <= i_eng.rx_data;
      rx_full_r <= 1'b1;
    end else if (rd_rx) begin
      rx_full_r <= 1'b0;
    end
  end

  // Lines follow on the write edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mlo_r <= scsml_pkg::MLO_RESET;
    end else if (soft_rst) begin
      mlo_r <= scsml_pkg::MLO_RESET;
    end else if (wr_modem) begin
      mlo_r <= wdata;
    end
  end

  // Read mux, answered one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_r  <= scsml_pkg::DAT_RESET;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rd_data || rd_modem;
      if (rd_data) begin
        rdata_r <= ctrl_access ? status_word : rx_data_r;
      end else if (rd_modem) begin
        rdata_r <= modem_in_word;
      end
    end
  end

  assign o_rdata      = rdata_r;
  assign o_rvalid     = rvalid_r;
  assign o_tx_wr      = tx_wr_r;
  assign o_tx_data    = tx_data_r;
  assign o_fmt_wr     = fmt_wr_r;
  assign o_fmt_data   = fmt_data_r;
  assign o_eng_idle   = eng_idle_r;
  assign o_tx_enable  = scw_r[scsml_pkg::SCW_TX_EN];
  assign o_rx_enable  = scw_r[scsml_pkg::SCW_RX_EN];
  assign o_send_break = scw_r[scsml_pkg::SCW_BREAK];
  assign o_hs_a       = scw_r[scsml_pkg::SCW_HS_A];
  assign o_hs_b       = scw_r[scsml_pkg::SCW_HS_B];
  assign o_half_rate  = mlo_r[scsml_pkg::MLO_HALF_RATE];
  // Same bits serve both cable layouts
  // Modem cable meaning of bits 3..0
  assign o_line_out   = mlo_r[3:0];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_scw_write_gate: assert property (
    (wr_data && !ctrl_access && !soft_rst) |=> $stable(scw_r))
    else $error("Control word changed in data mode");

  a_tx_pass_data: assert property (
    wr_tx |=> (o_tx_wr && (o_tx_data == $past(wdata))))
    else $error("Transmit byte not handed on");

  a_tx_block_off: assert property (
    (wr_data && !ctrl_access && !o_tx_enable) |=> !o_tx_wr)
    else $error("Transmit accepted while disabled");

  a_fmt_after_idle: assert property (
    (wr_ctrl && wdata[6] && !soft_rst) ##1 (wr_data && ctrl_access && !soft_rst)
      |=> (o_fmt_wr && $stable(scw_r)))
    else $error("Byte after idle not taken as line format");

  a_err_clear_bit: assert property (
    (wr_ctrl && wdata[4] && (err_set == 3'h0)) |=> (status_word[5:3] == 3'h0))
    else $error("Error flags not cleared");

  a_overrun_set: assert property (
    (rx_accept && rx_full_r && !rd_rx) |=> status_word[4] ##1
      (status_word[4] || $past(err_clr)))
    else $error("Overrun flag missing or not sticky");

  a_rx_gate_off: assert property (
    (i_eng.rx_new && !o_rx_enable && !rx_full_r) |=> !rx_full_r)
    else $error("Character accepted while receiver off");

  a_soft_reset_vals: assert property (
    soft_rst |=> ((scw_r == 8'h05) && (o_line_out == 4'h0) && !o_half_rate && !ctrl_access))
    else $error("Interface reset left state behind");

  a_status_read: assert property (
    (rd_data && ctrl_access) |=> (o_rvalid && !o_rdata[6] &&
                                  (o_rdata[1] == $past(rx_full_r))))
    else $error("Status word read wrong");

  a_modem_in_fixed: assert property (
    rd_modem |=> (o_rvalid && o_rdata[7] && (o_rdata[6:3] == 4'h0)))
    else $error("Modem-line input fixed bits wrong");

  a_line_out_follow: assert property (
    (wr_modem && !soft_rst) |=> ((o_line_out == $past(wdata[3:0])) &&
                                 (o_half_rate == $past(wdata[4]))))
    else $error("Modem-line outputs late or wrong");

  a_hs_follow: assert property (
    (wr_ctrl && !soft_rst) |=> ((o_hs_a == $past(wdata[5])) && (o_hs_b == $past(wdata[1]))))
    else $error("Handshake outputs late or wrong");

endmodule

`default_nettype wire

// ---- scsml_ctrl_test.sv ----
// Self-checking bench for the serial control and modem-line block
`default_nettype none

module scsml_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk = 1'b0;
  logic                  rst_b = 1'b0;
  logic                  cable = 1'b0;
  logic                  hs_in = 1'b0;
  logic [2:0]            sense = 3'h0;
  logic                  rx_go = 1'b0;
  logic [7:0]            rx_byte = 8'h00;
  logic                  pe = 1'b0;
  logic                  fe = 1'b0;
  logic                  brk = 1'b0;
  scsml_pkg::scsml_req_t req = '0;
  scsml_pkg::scsml_eng_t eng;
  logic [7:0]            rdata;
  logic [7:0]            tx_data;
  logic [7:0]            fmt_data;
  logic [7:0]            d;
  logic [3:0]            line_out;
  logic                  rvalid, tx_wr, fmt_wr, eng_idle, tx_en, rx_en, brk_o, half, hs_a, hs_b;
  int                    error_cnt = 0;
  int                    n_compared = 0;

  always #4 clk = ~clk;

  scsml_ctrl uut (.i_clk(clk), .i_rst_b(rst_b), .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_eng(eng), .o_tx_wr(tx_wr), .o_tx_data(tx_data), .o_fmt_wr(fmt_wr), .o_fmt_data(fmt_data),
    .o_eng_idle(eng_idle), .o_tx_enable(tx_en), .o_rx_enable(rx_en), .o_send_break(brk_o),
    .o_half_rate(half), .i_cable_modem(cable), .i_hs_in(hs_in), .i_sense(sense),
    .o_hs_a(hs_a), .o_hs_b(hs_b), .o_line_out(line_out));

  scsml_far far (.i_clk(clk), .i_rst_b(rst_b), .i_tx_wr(tx_wr), .i_rx_go(rx_go),
    .i_rx_byte(rx_byte), .i_pe(pe), .i_fe(fe), .i_brk(brk), .o_eng(eng));

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Control word as seen on the level outputs
  function automatic logic [7:0] img();
    return {2'b00, hs_a, 1'b0, brk_o, rx_en, hs_b, tx_en};
  endfunction

  // Bit 7 of every control write is zero
  task automatic wr(input logic [1:0] sel, input logic [7:0] v);
    @(negedge clk);
    req.wr = 1'b1;
    req.sel = sel;
    req.wdata = v;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // Two writes on consecutive edges
  task automatic wr2(input logic [1:0] sel, input logic [7:0] v1, input logic [7:0] v2);
    @(negedge clk);
    req.wr = 1'b1;
    req.sel = sel;
    req.wdata = v1;
    @(negedge clk);
    req.wdata = v2;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [1:0] sel, input logic [7:0] exp, input string what);
    @(negedge clk);
    req.rd = 1'b1;
    req.sel = sel;
    @(negedge clk);
    req.rd = 1'b0;
    chk("rvalid", {7'h0, rvalid}, {7'h0, sel != 2'h3});
    if (sel != 2'h3) chk(what, rdata, exp);
  endtask

  task automatic rx(input logic [7:0] b, input logic p, input logic f);
    @(negedge clk);
    rx_go = 1'b1;
    rx_byte = b;
    pe = p;
    fe = f;
    @(negedge clk);
    rx_go = 1'b0;
    pe = 1'b0;
    fe = 1'b0;
  endtask

  task automatic t_reset();
    chk("ctl reset", img(), 8'h05);
    chk("modem reset", {3'h0, half, line_out}, 8'h00);
  endtask

  task automatic t_ctrl();
    int bits[5] = '{0, 1, 2, 3, 5};
    wr(2'h1, 8'h01);
    foreach (bits[i]) begin
      wr(2'h0, 8'h01 << bits[i]);
      chk("ctl bit", img(), 8'h01 << bits[i]);
    end
    wr(2'h0, 8'h05);
  endtask

  task automatic t_status();
    hs_in = 1'b1;
    repeat (3) @(negedge clk);
    rd(2'h0, 8'h85, "status hs");
    hs_in = 1'b0;
    repeat (3) @(negedge clk);
    rd(2'h0, 8'h05, "status idle");
    wr(2'h0, 8'h04);
    rd(2'h0, 8'h04, "status tx off");
    wr(2'h0, 8'h05);
  endtask

  task automatic t_errors();
    rx(8'h3c, 1'b1, 1'b0);
    rx(8'hc3, 1'b0, 1'b1);
    repeat (4) @(negedge clk);
    rd(2'h0, 8'h3f, "status errors");
    wr(2'h0, 8'h15);
    rd(2'h0, 8'h07, "status cleared");
    wr(2'h1, 8'h00);
    rd(2'h0, 8'hc3, "rx data");
    wr(2'h1, 8'h01);
    rd(2'h0, 8'h05, "status drained");
    @(negedge clk);
    brk = 1'b1;
    @(negedge clk);
    brk = 1'b0;
    rd(2'h0, 8'h25, "status break");
    wr(2'h0, 8'h11);
    rx(8'h11, 1'b1, 1'b1);
    rd(2'h0, 8'h05, "status rx off");
    wr(2'h0, 8'h15);
  endtask

  task automatic t_data();
    wr(2'h1, 8'h00);
    wr(2'h0, 8'h5a);
    chk("tx pulse", {tx_wr, tx_data[6:0]}, 8'hda);
    chk("tx data", tx_data, 8'h5a);
    wr(2'h1, 8'h01);
    rd(2'h0, 8'h00, "status busy");
    wr(2'h0, 8'h04);
    wr(2'h1, 8'h00);
    wr(2'h0, 8'ha5);
    chk("tx dropped", {7'h0, tx_wr}, 8'h00);
    wr(2'h1, 8'h01);
    wr(2'h0, 8'h05);
  endtask

  task automatic t_fmt();
    wr(2'h0, 8'h45);
    chk("idle pulse", {7'h0, eng_idle}, 8'h01);
    wr(2'h0, 8'hcf);
    chk("fmt pulse", {7'h0, fmt_wr}, 8'h01);
    chk("fmt data", fmt_data, 8'hcf);
    chk("ctl kept", img(), 8'h05);
    wr2(2'h0, 8'h45, 8'h4e);
    chk("fmt b2b pulse", {7'h0, fmt_wr}, 8'h01);
    chk("fmt b2b data", fmt_data, 8'h4e);
    chk("ctl b2b kept", img(), 8'h05);
  endtask

  task automatic t_modem();
    sense = 3'h7;
    repeat (3) @(negedge clk);
    wr(2'h2, 8'h1f);
    chk("modem out", {3'h0, half, line_out}, 8'h1f);
    rd(2'h2, 8'h83, "term in");
    cable = 1'b1;
    repeat (3) @(negedge clk);
    rd(2'h2, 8'h87, "modem in");
    sense = 3'h5;
    repeat (3) @(negedge clk);
    rd(2'h2, 8'h85, "modem live");
    wr(2'h2, 8'h0a);
    chk("modem out b", {3'h0, half, line_out}, 8'h0a);
    rd(2'h3, 8'h00, "unmapped");
  endtask

  task automatic t_soft();
    wr(2'h0, 8'h2a);
    chk("ctl set", img(), 8'h2a);
    wr(2'h1, 8'h20);
    chk("soft ctl", img(), 8'h05);
    chk("soft modem", {3'h0, half, line_out}, 8'h00);
    chk("soft idle", {7'h0, eng_idle}, 8'h01);
    wr(2'h1, 8'h01);
    wr(2'h0, 8'h2a);
    wr(2'h2, 8'h1f);
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    chk("hw ctl", img(), 8'h05);
    chk("hw modem", {3'h0, half, line_out}, 8'h00);
  endtask

  // Whole run is about 130 cycles
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_ctrl();
    t_status();
    t_errors();
    t_data();
    t_fmt();
    t_modem();
    t_soft();
    end_of_test();
  end
endmodule

`default_nettype wire

// ---- scsml_err_flags.sv ----
// Sticky error flags with set winning over clear
`default_nettype none

module scsml_err_flags #(
  parameter int N = 3
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // Events and clear
  input  wire logic [N-1:0] i_set,
  input  wire logic         i_clr,
  output logic      [N-1:0] o_flags
);

  for (genvar g = 0; g < N; g++) begin : g_flag
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        o_flags[g] <= 1'b0;
      end else if (i_set[g]) begin
        o_flags[g] <= 1'b1;
      end else if (i_clr) begin
        o_flags[g] <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- scsml_far.sv ----
// Far-side model: serial engine reports and transmitter busy time
`default_nettype none

module scsml_far (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // From the block
  input  wire logic             i_tx_wr,
  // Bench commands
  input  wire logic             i_rx_go,
  input  wire logic [7:0]       i_rx_byte,
  input  wire logic             i_pe,
  input  wire logic             i_fe,
  input  wire logic             i_brk,
  // To the block
  output var scsml_pkg::scsml_eng_t o_eng
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] busy_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_r <= 4'h0;
    end else if (i_tx_wr) begin
      busy_r <= 4'h8;
    end else if (busy_r != 4'h0) begin
      busy_r <= busy_r - 4'h1;
    end
  end

  // Data outside a report is inverted, never left stale
  always_comb begin
    o_eng.tx_ready   = (busy_r == 4'h0);
    o_eng.tx_empty   = (busy_r == 4'h0);
    o_eng.rx_new     = i_rx_go;
    o_eng.rx_data    = i_rx_go ? i_rx_byte : ~i_rx_byte;
    o_eng.parity_err = i_pe;
    o_eng.frame_err  = i_fe;
    o_eng.break_det  = i_brk;
  end
endmodule

`default_nettype wire

// ---- scsml_pkg.sv ----
// Shared constants and carrier types for the serial control and modem-line block
`default_nettype none

package scsml_pkg;

  // Register select on the host I/O bus
  localparam logic [1:0] SEL_DATA  = 2'h0;
  localparam logic [1:0] SEL_ICW   = 2'h1;
  localparam logic [1:0] SEL_MODEM = 2'h2;

  // Interface control word fields
  localparam int ICW_CTRL_ACCESS = 0;
  localparam int ICW_SOFT_RESET  = 5;

  // Serial control word fields
  localparam int SCW_TX_EN     = 0;
  localparam int SCW_HS_B      = 1;
  localparam int SCW_RX_EN     = 2;
  localparam int SCW_BREAK     = 3;
  localparam int SCW_ERR_CLR   = 4;
  localparam int SCW_HS_A      = 5;
  localparam int SCW_ENG_RESET = 6;

  // Error flag indices inside the sticky flag vector
  localparam int ERR_PARITY  = 0;
  localparam int ERR_OVERRUN = 1;
  localparam int ERR_FRAMING = 2;
  localparam int ERR_COUNT   = 3;

  // Modem-line output fields
  localparam int MLO_HALF_RATE = 4;

  // Values after reset
  localparam logic [7:0] SCW_RESET = 8'h05;
  localparam logic [7:0] ICW_RESET = 8'h00;
  localparam logic [7:0] MLO_RESET = 8'h00;
  localparam logic [7:0] DAT_RESET = 8'h00;

  // Host request carrier
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } scsml_req_t;

  // Serial engine report carrier, same clock domain
  typedef struct packed {
    logic       tx_ready;
    logic       tx_empty;
    logic       rx_new;
    logic [7:0] rx_data;
    logic       parity_err;
    logic       frame_err;
    logic       break_det;
  } scsml_eng_t;

endpackage

`default_nettype wire

// ---- scsml_sync.sv ----
// Two-flop synchroniser for pin levels
`default_nettype none

module scsml_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // Levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

`default_nettype wire
